//--- design/pwm_timer_pkg.sv
// Constants, register map and carrier types for the dual PWM timer block.
// Assumes a 250 MHz system clock and a 32-bit Avalon-MM register port.
//
// Overview of operation
// - First timer counts on 16, 8, 4 or 2 MHz, or 32 kHz by default.
// - Divide-by-ten option slows only the interrupt-period counter.
// - Run bit starts timer: interrupt, load both counters, then decrement.
// - Phase counter reaching zero toggles phase and reloads from other shadow.
// - Primary output high in high phase; secondary output always its inverse.
// - Clock-output mode puts timer clock divided by two on high phase.
// - Period counter waits at zero for low-phase end, then interrupt and reload all.
// - New reload values reach shadows only at end of a full period.
// - An interrupt is also raised at start-up.
// - Disabled timer holds all state in reset except the software registers.
// - Reads return live period counter and live phase counter.
// - Freeze bit halts both counters until cleared through its reset register.
// - Counters and registers are 16 bits and reset to zero.
// - Second timer uses the 16 MHz base divided by 1, 2, 4 or 8 while enabled.
// - Shared 14-bit period counter counts down; at zero sets outputs and reloads.
// - Duty counter starts at zero; each output drops when it equals its duty.
// - Duty counter held in reset while the period value is zero.
// - With radio pause on, radio activity freezes duty counter and forces outputs low.
// - Clearing auto pause disables the radio-driven freeze.
// - Three outputs share both counters, each with its own duty value.

package pwm_timer_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_HIGH_RELOAD = 6'h00;
    localparam logic [5:0] ADDR_LOW_RELOAD = 6'h04;
    localparam logic [5:0] ADDR_PERIOD_RELOAD = 6'h08;
    localparam logic [5:0] ADDR_FIRST_CTRL = 6'h0C;
    localparam logic [5:0] ADDR_CLOCK_CTRL = 6'h10;
    localparam logic [5:0] ADDR_FREEZE_SET = 6'h14;
    localparam logic [5:0] ADDR_FREEZE_CLR = 6'h18;
    localparam logic [5:0] ADDR_TRIPLE_CTRL = 6'h1C;
    localparam logic [5:0] ADDR_TRIPLE_PERIOD = 6'h20;
    localparam logic [5:0] ADDR_DUTY0 = 6'h24;
    localparam logic [5:0] ADDR_DUTY1 = 6'h28;
    localparam logic [5:0] ADDR_DUTY2 = 6'h2C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // first_timer_control
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_FAST_SEL_BIT = 1;
    localparam int CTRL_DIV10_BIT = 2;
    localparam int CTRL_CLKOUT_BIT = 3;
    // clock control: gate bit and 2-bit divider
    localparam int CLK_GATE_BIT = 0;
    localparam int CLK_DIV_LSB = 1;
    // freeze set/clear
    localparam int FREEZE_BIT = 0;
    // triple_out_control
    localparam int TRIPLE_EN_BIT = 0;
    localparam int TRIPLE_HW_PAUSE_BIT = 1;
    localparam int TRIPLE_SW_PAUSE_BIT = 2;

    // ------------------------------------------------------------
    // Widths, reset values, timing
    // ------------------------------------------------------------
    localparam int FIRST_W = 16;
    localparam int TRIPLE_W = 14;
    localparam int NUM_TRIPLE = 3;
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    localparam logic [3:0] PERIOD_DIVIDE = 4'h9;          // Divide by ten: counts 0..9
    localparam int SYS_CLK_HZ = 250_000_000;
    localparam int FAST_BASE_HZ = 16_000_000;
    localparam int SLOW_HZ = 32_768;
    localparam logic [4:0] FAST_TICK_CYCLES = 5'(SYS_CLK_HZ / FAST_BASE_HZ);
    localparam logic [12:0] SLOW_TICK_CYCLES = 13'(SYS_CLK_HZ / SLOW_HZ);

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avmm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avmm_rsp_t;

    typedef struct packed {
        logic primary_pwm_out;
        logic inverted_pwm_out;
        logic first_timer_interrupt;
        logic [NUM_TRIPLE-1:0] triple_output_n;
    } pwm_outs_t;

endpackage : pwm_timer_pkg

//--- design/tick_divider.sv
// Tick generator: one-cycle pulse every limit+1 ticks of an incoming strobe.
// Assumes the strobe and reset belong to the system clock domain.
`timescale 1ns/1ns
`default_nettype none

module tick_divider #(
    parameter int W = 13
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Control
    input wire logic clear,
    input wire logic strobe_in,
    input wire logic [W-1:0] limit,
    // Result
    output logic tick_out
);
    typedef struct packed {
        logic [W-1:0] count;
        logic tick;
    } div_state_t;

    div_state_t state_q;
    div_state_t state_d;

    // Count strobes; wrap at the limit and emit one pulse
    always_comb
    begin
        state_d = state_q;
        state_d.tick = 1'b0;
        if (clear)
        begin
            state_d.count = '0;
        end
        else if (strobe_in)
        begin
            if (state_q.count >= limit)
            begin
                state_d.count = '0;
                state_d.tick = 1'b1;
            end
            else
            begin
                state_d.count = state_q.count + W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign tick_out = state_q.tick;

endmodule : tick_divider
`default_nettype wire

//--- design/dual_pwm_timer_block.sv
// Dual PWM timer: a 16-bit two-phase PWM timer with periodic interrupt and a
// 14-bit triple PWM generator, programmed over Avalon-MM.
// Assumes radio activity inputs arrive asynchronously from another block.
`timescale 1ns/1ns
`default_nettype none

module dual_pwm_timer_block (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register bus
    input wire pwm_timer_pkg::avmm_req_t bus_req,
    output pwm_timer_pkg::avmm_rsp_t bus_rsp,
    // Radio activity
    input wire logic radio_rx_active,
    input wire logic radio_tx_active,
    // Outputs to loads
    output pwm_timer_pkg::pwm_outs_t pwm_outs
);
    import pwm_timer_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_HIGH,
        PH_LOW
    } phase_t;

    typedef struct packed {
        // Software registers
        logic [15:0] high_phase_reload;
        logic [15:0] low_phase_reload;
        logic [15:0] interrupt_period_reload;
        logic [3:0] first_timer_control;
        logic [2:0] clock_control;
        logic first_timer_freeze;
        logic [2:0] triple_out_control;
        logic [13:0] triple_out_period;
        logic [2:0][13:0] per_output_duty;
        // First timer
        phase_t phase;
        logic [15:0] pwm_phase_counter;
        logic [15:0] period_counter;
        logic [15:0] high_shadow;
        logic [15:0] low_shadow;
        logic clk_half;
        logic irq;
        // Second timer
        logic [13:0] shared_period_counter;
        logic [13:0] shared_duty_counter;
        logic [2:0] triple_q;
        // Bus and synchroniser
        logic ack;
        logic [31:0] rdata;
        logic [2:0] radio_sync;
        logic radio_held;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Decode of a 2-bit divider field: base plus one, times a power of two, minus one
    function automatic logic [12:0] div_limit(input logic [1:0] sel, input logic [12:0] base);
        div_limit = 13'((({9'h000, base} + 22'h1) << sel) - 22'h1);
    endfunction : div_limit

    // ------------------------------------------------------------
    // Tick generation
    // ------------------------------------------------------------
    logic first_run;
    logic fast_sel;
    logic fast_ok;
    logic sys_strobe;
    logic slow_tick;
    logic fast_tick;
    logic timer_tick;
    logic period_tick;
    logic triple_tick;
    logic timer_live;

    assign first_run = s_q.first_timer_control[CTRL_RUN_BIT];
    assign fast_sel = s_q.first_timer_control[CTRL_FAST_SEL_BIT];
    assign fast_ok = s_q.clock_control[CLK_GATE_BIT];
    assign sys_strobe = 1'b1;

    // Slow 32 kHz tick, always running
    tick_divider #(.W(13)) u_slow (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clear(1'b0),
        .strobe_in(sys_strobe),
        .limit(SLOW_TICK_CYCLES - 13'h1),
        .tick_out(slow_tick)
    );

    // Fast tick: 16 MHz base divided by 1, 2, 4 or 8 through the divider field
    tick_divider #(.W(13)) u_fast (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clear(!fast_ok),
        .strobe_in(sys_strobe),
        .limit(div_limit(s_q.clock_control[CLK_DIV_LSB +: 2], 13'(FAST_TICK_CYCLES) - 13'h1)),
        .tick_out(fast_tick)
    );

    // Fast choice needs the gate bit as well; slow is the reset default
    assign timer_tick = fast_sel ? (fast_tick && fast_ok) : slow_tick;
    assign timer_live = timer_tick && first_run && !s_q.first_timer_freeze;

    // Optional divide by ten feeds only the period counter
    tick_divider #(.W(4)) u_div10 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clear(!first_run),
        .strobe_in(timer_live),
        .limit(PERIOD_DIVIDE),
        .tick_out(period_tick)
    );

    // Second timer shares the fast tick path (16 MHz base divided by 1..8)
    assign triple_tick = fast_tick && fast_ok;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic radio_busy;
    logic period_step;
    logic at_period_end;
    logic triple_en;
    logic pause_now;

    always_comb
    begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.irq = 1'b0;

        // Three-stage radio synchroniser; change counted when stages 2 and 3 agree
        s_d.radio_sync = {s_q.radio_sync[1:0], radio_rx_active || radio_tx_active};
        if (s_q.radio_sync[1] == s_q.radio_sync[2])
        begin
            s_d.radio_held = s_q.radio_sync[2];
        end
        radio_busy = s_q.radio_held;

        // Bus: one-cycle wait then answer, keeps the response registered
        if (bus_req.read || bus_req.write)
        begin
            s_d.ack = !s_q.ack;
            // A write lands only at the edge where waitrequest is seen low
            if (bus_req.write && s_q.ack)
            begin
                case (bus_req.address)
                    ADDR_HIGH_RELOAD: s_d.high_phase_reload = bus_req.writedata[15:0];
                    ADDR_LOW_RELOAD: s_d.low_phase_reload = bus_req.writedata[15:0];
                    ADDR_PERIOD_RELOAD: s_d.interrupt_period_reload = bus_req.writedata[15:0];
                    ADDR_FIRST_CTRL: s_d.first_timer_control = bus_req.writedata[3:0];
                    ADDR_CLOCK_CTRL: s_d.clock_control = bus_req.writedata[2:0];
                    ADDR_FREEZE_SET:
                    begin
                        if (bus_req.writedata[FREEZE_BIT])
                        begin
                            s_d.first_timer_freeze = 1'b1;
                        end
                    end
                    ADDR_FREEZE_CLR:
                    begin
                        if (bus_req.writedata[FREEZE_BIT])
                        begin
                            s_d.first_timer_freeze = 1'b0;
                        end
                    end
                    ADDR_TRIPLE_CTRL: s_d.triple_out_control = bus_req.writedata[2:0];
                    ADDR_TRIPLE_PERIOD: s_d.triple_out_period = bus_req.writedata[13:0];
                    ADDR_DUTY0: s_d.per_output_duty[0] = bus_req.writedata[13:0];
                    ADDR_DUTY1: s_d.per_output_duty[1] = bus_req.writedata[13:0];
                    ADDR_DUTY2: s_d.per_output_duty[2] = bus_req.writedata[13:0];
                    default: ;
                endcase
            end
            else if (bus_req.read && !s_q.ack)
            begin
                // Reload addresses return live counters, not stored values
                case (bus_req.address)
                    ADDR_HIGH_RELOAD: s_d.rdata = {16'h0000, s_q.pwm_phase_counter};
                    ADDR_LOW_RELOAD: s_d.rdata = {16'h0000, s_q.pwm_phase_counter};
                    ADDR_PERIOD_RELOAD: s_d.rdata = {16'h0000, s_q.period_counter};
                    ADDR_FIRST_CTRL: s_d.rdata = {28'h000_0000, s_q.first_timer_control};
                    ADDR_CLOCK_CTRL: s_d.rdata = {29'h0000_0000, s_q.clock_control};
                    ADDR_FREEZE_SET: s_d.rdata = {31'h0000_0000, s_q.first_timer_freeze};
                    ADDR_TRIPLE_CTRL: s_d.rdata = {29'h0000_0000, s_q.triple_out_control};
                    ADDR_TRIPLE_PERIOD: s_d.rdata = {18'h0_0000, s_q.triple_out_period};
                    ADDR_DUTY0: s_d.rdata = {18'h0_0000, s_q.per_output_duty[0]};
                    ADDR_DUTY1: s_d.rdata = {18'h0_0000, s_q.per_output_duty[1]};
                    ADDR_DUTY2: s_d.rdata = {18'h0_0000, s_q.per_output_duty[2]};
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
        end

        // First timer; disabled means everything but the software registers is cleared
        period_step = s_q.first_timer_control[CTRL_DIV10_BIT] ? period_tick : timer_live;
        at_period_end = (s_q.phase == PH_LOW) && (s_q.pwm_phase_counter == '0)
            && (s_q.period_counter == '0);
        if (!first_run)
        begin
            s_d.phase = PH_IDLE;
            s_d.pwm_phase_counter = RESET_VALUE;
            s_d.period_counter = RESET_VALUE;
            s_d.high_shadow = RESET_VALUE;
            s_d.low_shadow = RESET_VALUE;
            s_d.clk_half = 1'b0;
        end
        else
        begin
            case (s_q.phase)
                PH_IDLE:
                begin
                    // Counters and output start low, so start-up raises the interrupt
                    if (timer_live)
                    begin
                        s_d.irq = 1'b1;
                        s_d.high_shadow = s_q.high_phase_reload;
                        s_d.low_shadow = s_q.low_phase_reload;
                        s_d.pwm_phase_counter = s_q.high_phase_reload;
                        s_d.period_counter = s_q.interrupt_period_reload;
                        s_d.phase = PH_HIGH;
                    end
                end
                PH_HIGH, PH_LOW:
                begin
                    if (timer_live)
                    begin
                        s_d.clk_half = !s_q.clk_half;
                        if (at_period_end)
                        begin
                            // Full cycle done: pulse interrupt and take new values
                            s_d.irq = 1'b1;
                            s_d.high_shadow = s_q.high_phase_reload;
                            s_d.low_shadow = s_q.low_phase_reload;
                            s_d.pwm_phase_counter = s_q.high_phase_reload;
                            s_d.period_counter = s_q.interrupt_period_reload;
                            s_d.phase = PH_HIGH;
                        end
                        else if (s_q.pwm_phase_counter == '0)
                        begin
                            // Alternate between shadows
                            s_d.phase = (s_q.phase == PH_HIGH) ? PH_LOW : PH_HIGH;
                            s_d.pwm_phase_counter = (s_q.phase == PH_HIGH) ? s_q.low_shadow
                                : s_q.high_shadow;
                        end
                        else
                        begin
                            s_d.pwm_phase_counter = s_q.pwm_phase_counter - 16'h0001;
                        end
                    end
                    // Period counter parks at zero until the low phase ends
                    if (period_step && (s_q.period_counter != '0) && !at_period_end)
                    begin
                        s_d.period_counter = s_q.period_counter - 16'h0001;
                    end
                end
                default: s_d.phase = PH_IDLE;
            endcase
        end

        // Second timer
        triple_en = s_q.triple_out_control[TRIPLE_EN_BIT];
        pause_now = s_q.triple_out_control[TRIPLE_HW_PAUSE_BIT]
            && s_q.triple_out_control[TRIPLE_SW_PAUSE_BIT] && radio_busy;
        if (!triple_en)
        begin
            s_d.shared_period_counter = '0;
            s_d.shared_duty_counter = '0;
            s_d.triple_q = '0;
        end
        else if (triple_tick)
        begin
            if (s_q.shared_period_counter == '0)
            begin
                // Period start: outputs high, both counters restart
                s_d.shared_period_counter = s_q.triple_out_period;
                s_d.shared_duty_counter = '0;
                s_d.triple_q = '1;
            end
            else
            begin
                s_d.shared_period_counter = s_q.shared_period_counter - 14'h0001;
                if (!pause_now)
                begin
                    s_d.shared_duty_counter = s_q.shared_duty_counter + 14'h0001;
                end
            end
            for (int i = 0; i < NUM_TRIPLE; i++)
            begin
                if ((s_q.shared_period_counter != '0) && (s_q.shared_duty_counter == s_q.per_output_duty[i]))
                begin
                    s_d.triple_q[i] = 1'b0;
                end
            end
        end
        if (s_q.triple_out_period == '0)
        begin
            s_d.shared_duty_counter = '0;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic high_level;
    logic paused_out;

    // In clock-output mode the high phase carries the halved timer clock
    assign high_level = (s_q.phase == PH_HIGH)
        && (!s_q.first_timer_control[CTRL_CLKOUT_BIT] || s_q.clk_half);
    assign paused_out = s_q.triple_out_control[TRIPLE_HW_PAUSE_BIT]
        && s_q.triple_out_control[TRIPLE_SW_PAUSE_BIT] && s_q.radio_held;

    always_comb
    begin
        pwm_outs.primary_pwm_out = high_level;
        pwm_outs.inverted_pwm_out = !high_level;
        pwm_outs.first_timer_interrupt = s_q.irq;
        pwm_outs.triple_output_n = paused_out ? 3'b000 : s_q.triple_q;
        bus_rsp.readdata = s_q.rdata;
        bus_rsp.waitrequest = (bus_req.read || bus_req.write) && !s_q.ack;
    end

endmodule : dual_pwm_timer_block
`default_nettype wire

//--- tb/dual_pwm_timer_chk.sv
// Port checker for the dual PWM timer block.
// Assumes it is bound onto dual_pwm_timer_block.
`timescale 1ns/1ns
`default_nettype none
module dual_pwm_timer_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Watched ports
    input wire pwm_timer_pkg::avmm_req_t bus_req,
    input wire pwm_timer_pkg::avmm_rsp_t bus_rsp,
    input wire pwm_timer_pkg::pwm_outs_t pwm_outs
);
    import pwm_timer_pkg::*;
    logic rd_done;
    // ----
    // Bus and output properties
    // ----
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Read answered at this edge
    assign rd_done = bus_req.read && !bus_rsp.waitrequest;
    sequence req_rise; $rose(bus_req.read || bus_req.write); endsequence
    sequence one_wait; bus_rsp.waitrequest ##1 !bus_rsp.waitrequest; endsequence
    wait_one_a: assert property (req_rise |-> one_wait)
        else $error("waitrequest not one cycle");
    hold_data_a: assert property (!(bus_req.read || bus_req.write) |=> $stable(bus_rsp.readdata))
        else $error("readdata changed while idle");
    unmapped_zero_a: assert property (rd_done && bus_req.address > ADDR_DUTY2 |-> bus_rsp.readdata == '0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (rd_done |-> bus_rsp.readdata[31:16] == '0)
        else $error("upper read bits set");
    ctrl_width_a: assert property (rd_done && bus_req.address == ADDR_FIRST_CTRL |-> bus_rsp.readdata[31:4] == '0)
        else $error("control read too wide");
    triple_width_a: assert property (rd_done && bus_req.address >= ADDR_TRIPLE_PERIOD |-> bus_rsp.readdata[31:14] == '0)
        else $error("triple read too wide");
    inverse_out_a: assert property (pwm_outs.inverted_pwm_out == !pwm_outs.primary_pwm_out)
        else $error("secondary output not inverse");
    irq_pulse_a: assert property (pwm_outs.first_timer_interrupt |=> !pwm_outs.first_timer_interrupt)
        else $error("interrupt longer than one cycle");
endmodule : dual_pwm_timer_chk
bind dual_pwm_timer_block dual_pwm_timer_chk u_dual_pwm_timer_chk (.sys_clk(sys_clk), .rst_b(rst_b),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .pwm_outs(pwm_outs));
`default_nettype wire

//--- tb/pwm_load.sv
// Load model on one PWM line: measures high time, period and rising edges.
// Assumes the line is a registered level in the sys_clk domain.
`timescale 1ns/1ns
`default_nettype none
module pwm_load (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Load line and measurements
    input wire logic lvl,
    output int high_n,
    output int period_n,
    output int rises_n
);
    int hc;
    int pc;
    logic last;
    // Latch counts at each rising edge; a paused line keeps its last figures
    always @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            hc <= 0;
            pc <= 0;
            rises_n <= 0;
            last <= 1'b0;
        end
        else
        begin
            last <= lvl;
            hc <= (lvl && !last) ? 1 : hc + int'(lvl);
            pc <= (lvl && !last) ? 1 : pc + 1;
            if (lvl && !last)
            begin
                high_n <= hc;
                period_n <= pc;
                rises_n <= rises_n + 1;
            end
        end
endmodule : pwm_load
`default_nettype wire

//--- tb/dual_pwm_timer_block_tb.sv
// Self-checking bench for the dual PWM timer block.
// Assumes the fast tick is 15 cycles and the bus answers after one cycle.
`timescale 1ns/1ns
`default_nettype none
module dual_pwm_timer_block_tb;
    import pwm_timer_pkg::*;
    logic sys_clk, rst_b, rx, tx;
    avmm_req_t req;
    avmm_rsp_t rsp;
    pwm_outs_t outs;
    int bad_count, check_count, irqs, n1, p, hi0, per0, hi2, per2, r2;
    logic [31:0] expq[$];
    logic [13:0] d[3];
    dual_pwm_timer_block u_dual_pwm_timer_block (.sys_clk(sys_clk), .rst_b(rst_b), .bus_req(req),
        .bus_rsp(rsp), .radio_rx_active(rx), .radio_tx_active(tx), .pwm_outs(outs));
    pwm_load u_pwm_load (.sys_clk(sys_clk), .rst_b(rst_b), .lvl(outs.primary_pwm_out),
        .high_n(hi0), .period_n(per0), .rises_n());
    pwm_load u_pwm_load_triple (.sys_clk(sys_clk), .rst_b(rst_b), .lvl(outs.triple_output_n[0]),
        .high_n(hi2), .period_n(per2), .rises_n(r2));
    // ----
    // Clock, watchdog and checking tasks
    // ----
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        test_done();
    end
    // Count interrupt pulses
    always @(posedge sys_clk)
        if (outs.first_timer_interrupt === 1'b1)
            irqs <= irqs + 1;
    // Each answered read takes the oldest expectation
    always @(posedge sys_clk)
        if (req.read && rsp.waitrequest === 1'b0)
            compare("readdata", expq.pop_front(), rsp.readdata);
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : compare
    // Hold the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        req <= '{address: a, read: rd, write: !rd, writedata: wd};
        do @(posedge sys_clk); while (rsp.waitrequest !== 1'b0 && ++n < 100);
        if (n >= 100) compare("waitrequest", 0, 1);
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] wd); bus(1'b0, a, wd); endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] e); expq.push_back(e); bus(1'b1, a, '0); endtask : rd
    task automatic idle(input int n); repeat (n) @(posedge sys_clk); endtask : idle
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    // ----
    // Test sequence
    // ----
    initial
    begin
        {rst_b, rx, tx, req} = '0;
        p = $urandom(32'h974b414d);
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int a = 0; a <= 'h30; a += 4) rd(6'(a), 0);
        wr(ADDR_HIGH_RELOAD, 2);
        wr(ADDR_LOW_RELOAD, 1);
        wr(6'h30, 32'hFFFF_FFFF);
        rd(ADDR_HIGH_RELOAD, 0);
        rd(6'h30, 0);
        $display("test reset and disabled reads done");
        wr(ADDR_CLOCK_CTRL, 1);
        wr(ADDR_FIRST_CTRL, 3);
        idle(40);
        compare("start irq", 1, irqs > 0);
        idle(400);
        compare("high time", 45, hi0);
        compare("pwm period", 75, per0);
        n1 = irqs;
        idle(750);
        compare("irq count", 10, irqs - n1);
        wr(ADDR_HIGH_RELOAD, 5);
        idle(400);
        compare("new high time", 90, hi0);
        $display("test first timer run done");
        wr(ADDR_FREEZE_SET, 1);
        rd(ADDR_FREEZE_SET, 1);
        n1 = irqs;
        idle(400);
        compare("frozen irq", n1, irqs);
        wr(ADDR_FREEZE_CLR, 1);
        rd(ADDR_FREEZE_SET, 0);
        idle(400);
        compare("resumed irq", 1, irqs > n1);
        wr(ADDR_FIRST_CTRL, 0);
        rd(ADDR_PERIOD_RELOAD, 0);
        idle(20);
        compare("disabled out", 0, outs.primary_pwm_out);
        wr(ADDR_FIRST_CTRL, 11);
        idle(400);
        compare("clock out high", 15, hi0);
        $display("test freeze and disable done");
        p = 3 + $urandom % 8;
        d[0] = 14'($urandom % p);
        d[1] = 14'($urandom % (p + 1));
        d[2] = 14'(p);
        wr(ADDR_TRIPLE_PERIOD, p);
        for (int i = 0; i < 3; i++) wr(6'(ADDR_DUTY0 + 4 * i), d[i]);
        for (int i = 0; i < 3; i++) rd(6'(ADDR_DUTY0 + 4 * i), d[i]);
        wr(ADDR_TRIPLE_CTRL, 7);
        idle(800);
        compare("triple period", (p + 1) * 15, per2);
        compare("triple high", (d[0] + 1) * 15, hi2);
        compare("full duty", 1, outs.triple_output_n[2]);
        rx <= 1'b1;
        idle(20);
        repeat (10)
        begin
            idle(10);
            compare("paused outs", 0, outs.triple_output_n);
        end
        n1 = r2;
        wr(ADDR_TRIPLE_CTRL, 3);
        idle(400);
        compare("no pause", 1, r2 > n1);
        rx <= 1'b0;
        tx <= 1'b1;
        wr(ADDR_TRIPLE_CTRL, 7);
        idle(20);
        compare("tx paused", 0, outs.triple_output_n);
        tx <= 1'b0;
        wr(ADDR_TRIPLE_CTRL, 0);
        idle(20);
        compare("triple off", 0, outs.triple_output_n);
        $display("test triple outputs done");
        test_done();
    end
endmodule : dual_pwm_timer_block_tb
`default_nettype wire
